// ### rtl/psm_pkg.sv
// package: constants and carriers for the pump switch mode configuration
package psm_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned RESTART_SEC = 10;
  localparam int unsigned DISPLAY_SEC = 60;
  localparam int unsigned MONITOR_MIN = 15;
  localparam int unsigned MIN_SEC = 60;
  localparam int unsigned SEC_CYCLES = CLK_HZ;

  // ---------------------------------------------------------------
  // bank and switch positions
  // ---------------------------------------------------------------
  localparam logic [1:0] BANK_A = 2'h0;
  localparam logic [1:0] BANK_B = 2'h1;
  localparam logic [1:0] BANK_C = 2'h2;
  localparam logic [2:0] SW_1 = 3'h0;
  localparam logic [2:0] SW_2 = 3'h1;
  localparam logic [2:0] SW_3 = 3'h2;
  localparam logic [2:0] SW_4 = 3'h3;
  localparam logic [2:0] SW_6 = 3'h5;
  localparam logic [2:0] SW_7 = 3'h6;
  localparam logic [2:0] SW_8 = 3'h7;

  // ---------------------------------------------------------------
  // factory settings (bit n = switch n+1)
  // ---------------------------------------------------------------
  localparam logic [7:0] RESET_BANK_A = 8'h05;
  localparam logic [7:0] RESET_BANK_B = 8'h20;
  localparam logic [7:0] RESET_BANK_C = 8'h00;

  // ---------------------------------------------------------------
  // serial frame lengths
  // ---------------------------------------------------------------
  localparam logic [3:0] DATA_LEN_SHORT = 4'h7;
  localparam logic [3:0] DATA_LEN_LONG = 4'h8;

  // ---------------------------------------------------------------
  // register map of the plain bus
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_BANK_A = 4'h0;
  localparam logic [3:0] ADDR_BANK_B = 4'h1;
  localparam logic [3:0] ADDR_BANK_C = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;

  // interrupt bit positions
  localparam int unsigned IRQ_COMMIT = 0;
  localparam int unsigned IRQ_REJECT = 1;
  localparam int unsigned IRQ_RESTART_DONE = 2;
  localparam int unsigned IRQ_ABORT = 3;
  localparam int unsigned IRQ_W = 4;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  // operator keys on the switch-setting screen, one-cycle pulses
  typedef struct packed {
    logic enter_screen;
    logic leave_screen;
    logic step;
    logic set_on;
    logic set_off;
    logic stop;
    logic reset;
  } psm_keys_t;

  // decoded mode outputs
  typedef struct packed {
    logic [3:0] data_len;
    logic buzzer_en;
    logic dilution_gas_off_mode;
    logic booster_ext_start;
    logic primary_stage_ext_speed;
    logic booster_stage_ext_speed;
    logic special_if_en;
    logic display_locked;
  } psm_modes_t;

  // session state
  typedef enum logic [1:0] {
    PSM_IDLE,
    PSM_EDIT
  } psm_state_t;

endpackage

// ### rtl/psm_switch_mode.sv
// pump switch mode configuration: setting banks, edits, mode outputs
// Operation
// - A1 selects 7 or 8 bit status frames
// - A2: constant or run-plus-15-minute monitoring
// - A3 gates buzzer on warnings and alarms
// - A4 off: remote follows external start
// - A4 on: remote transition stops pump
// - A3 and A4 editable anytime
// - non-buzzer edit starts ten-second countdown
// - A7 selects dilution-gas-off mode
// - A8 selects booster start under remote
// - B1 enables external primary speed
// - B2 enables external booster speed
// - B6 off enables special interface, mutes connectors
// - B8 locks display, else sixty-second return
// - C1 sets warning contact polarity
// - keys step switch and set value
// - stop and reset keys work while editing
// - warning or alarm ends edit session
// - running pump rejects most switch edits
`timescale 1ns/1ps
`default_nettype none
module psm_switch_mode #(
  parameter int unsigned RESTART_CYCLES =
    psm_pkg::RESTART_SEC * psm_pkg::SEC_CYCLES,
  parameter int unsigned DISPLAY_CYCLES =
    psm_pkg::DISPLAY_SEC * psm_pkg::SEC_CYCLES,
  parameter longint unsigned MONITOR_CYCLES =
    64'(psm_pkg::MONITOR_MIN) * psm_pkg::MIN_SEC * psm_pkg::SEC_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register bus
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  output logic irq,
  // display controller keys and bank selection
  input wire psm_pkg::psm_keys_t keys,
  input wire logic [1:0] key_bank,
  input wire logic display_activity,
  // pump and remote status
  input wire logic pump_running,
  input wire logic remote_mode,
  input wire logic ext_start,
  input wire logic ext_booster_start,
  input wire logic warn_alarm,
  input wire logic purge_gas_warning,
  input wire logic [7:0] ext_primary_speed,
  input wire logic [7:0] ext_booster_speed,
  input wire logic [7:0] local_primary_speed,
  input wire logic [7:0] local_booster_speed,
  input wire logic local_run_cmd,
  input wire logic [1:0] conn_signals,
  // drive and indicator outputs
  output psm_pkg::psm_modes_t modes,
  output logic run_cmd_q,
  output logic booster_run_q,
  output logic [7:0] primary_speed_q,
  output logic [7:0] booster_speed_q,
  output logic monitor_en_q,
  output logic buzzer_q,
  output logic purge_gas_warning_output,
  output logic direct_signal_connector_one,
  output logic direct_signal_connector_two,
  output logic restart_busy,
  output logic display_home_q,
  output logic edit_active,
  output logic [2:0] edit_sel,
  output logic stop_pulse,
  output logic clear_pulse
);
  // ---------------------------------------------------------------
  // setting banks and session state
  // ---------------------------------------------------------------
  logic [7:0] bank_a_q, bank_b_q, bank_c_q; // committed settings
  psm_pkg::psm_state_t state_q; // edit session state
  logic [2:0] sel_q; // selected switch number
  logic [31:0] restart_cnt_q; // power-on style countdown
  logic [31:0] display_cnt_q; // display return timer
  logic [39:0] monitor_cnt_q; // post-stop monitoring timer
  logic remote_q, remote_hold_q; // previous remote level, start hold
  localparam int unsigned IRQ_W_L = psm_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] irq_stat_q, irq_mask_q; // interrupt status, mask
  // an edit request from keys or bus
  logic key_edit; // key set on/off in session
  logic key_val; // value from keys
  logic bus_edit; // bus write to a bank
  logic [1:0] ed_bank; // bank being edited
  logic [7:0] ed_new; // bank value after edit
  logic [7:0] ed_old; // bank value before edit
  logic [7:0] ed_free; // bits editable while running
  logic ed_req, ed_ok, ed_restart;
  logic restart_done;
  assign key_edit = (state_q == psm_pkg::PSM_EDIT) &&
                    (keys.set_on || keys.set_off) && !warn_alarm;
  assign key_val = keys.set_on;
  assign bus_edit = bus_wr && (bus_addr <= psm_pkg::ADDR_BANK_C);
  // ---------------------------------------------------------------
  // edit decode
  // ---------------------------------------------------------------
  always_comb begin
    ed_bank = key_edit ? key_bank : bus_addr[1:0];
    ed_old = 8'h00;
    ed_free = 8'h00;
    case (ed_bank)
      psm_pkg::BANK_A: begin
        ed_old = bank_a_q;
        ed_free[psm_pkg::SW_3] = 1'b1;
        ed_free[psm_pkg::SW_4] = 1'b1;
      end
      psm_pkg::BANK_B: begin
        ed_old = bank_b_q;
        ed_free[psm_pkg::SW_8] = 1'b1;
      end
      psm_pkg::BANK_C: ed_old = bank_c_q;
      default: ed_old = 8'h00;
    endcase
    ed_new = ed_old;
    if (key_edit) begin
      ed_new[sel_q] = key_val;
    end else begin
      ed_new = bus_wdata;
    end
  end
  assign ed_req = (key_edit || bus_edit) && (ed_bank != 2'h3);
  assign ed_ok = ed_req &&
                 (!pump_running || (((ed_new ^ ed_old) & ~ed_free) == 8'h00));
  assign ed_restart = ed_ok &&
    (((ed_new ^ ed_old) & ~((ed_bank == psm_pkg::BANK_A) ?
      (8'h01 << psm_pkg::SW_3) : 8'h00)) != 8'h00);
  // ---------------------------------------------------------------
  // commit of settings
  // ---------------------------------------------------------------
  // single-edge commit
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bank_a_q <= psm_pkg::RESET_BANK_A;
      bank_b_q <= psm_pkg::RESET_BANK_B;
      bank_c_q <= psm_pkg::RESET_BANK_C;
    end else if (ed_ok) begin
      case (ed_bank)
        psm_pkg::BANK_A: bank_a_q <= ed_new;
        psm_pkg::BANK_B: bank_b_q <= ed_new;
        psm_pkg::BANK_C: bank_c_q <= ed_new;
        default: bank_a_q <= bank_a_q;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // edit session
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= psm_pkg::PSM_IDLE;
      sel_q <= 3'h0;
    end else begin
      case (state_q)
        psm_pkg::PSM_IDLE: begin
          if (keys.enter_screen && !warn_alarm) begin
            state_q <= psm_pkg::PSM_EDIT;
            sel_q <= 3'h0;
          end
        end
        psm_pkg::PSM_EDIT: begin
          if (warn_alarm || keys.leave_screen) begin
            state_q <= psm_pkg::PSM_IDLE;
          end else if (keys.step) begin
            sel_q <= sel_q + 3'h1;
          end
        end
        default: state_q <= psm_pkg::PSM_IDLE;
      endcase
    end
  end
  assign edit_active = (state_q == psm_pkg::PSM_EDIT);
  assign edit_sel = sel_q;
  assign stop_pulse = keys.stop;
  assign clear_pulse = keys.reset;
  // ---------------------------------------------------------------
  // restart countdown
  // ---------------------------------------------------------------
  // ten-second countdown
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      restart_cnt_q <= 32'(RESTART_CYCLES);
    end else if (ed_restart) begin
      restart_cnt_q <= 32'(RESTART_CYCLES);
    end else if (restart_cnt_q != 32'h0) begin
      restart_cnt_q <= restart_cnt_q - 32'h1;
    end
  end
  assign restart_busy = (restart_cnt_q != 32'h0);
  assign restart_done = (restart_cnt_q == 32'h1) && !ed_restart;
  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  always_comb begin
    modes.data_len = bank_a_q[psm_pkg::SW_1] ?
      psm_pkg::DATA_LEN_LONG : psm_pkg::DATA_LEN_SHORT;
    modes.buzzer_en = bank_a_q[psm_pkg::SW_3];
    modes.dilution_gas_off_mode = bank_a_q[psm_pkg::SW_7];
    modes.booster_ext_start = bank_a_q[psm_pkg::SW_8];
    modes.primary_stage_ext_speed = bank_b_q[psm_pkg::SW_1];
    modes.booster_stage_ext_speed = bank_b_q[psm_pkg::SW_2];
    modes.special_if_en = !bank_b_q[psm_pkg::SW_6];
    modes.display_locked = bank_b_q[psm_pkg::SW_8];
  end
  // ---------------------------------------------------------------
  // pump run control
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      remote_q <= 1'b0;
      remote_hold_q <= 1'b0;
      run_cmd_q <= 1'b0;
      booster_run_q <= 1'b0;
    end else begin
      remote_q <= remote_mode;
      // hold remote start until seen low
      if (remote_mode && !remote_q) begin
        remote_hold_q <= bank_a_q[psm_pkg::SW_4];
      end else if (!ext_start) begin
        remote_hold_q <= 1'b0;
      end
      if (keys.stop || restart_busy) begin
        run_cmd_q <= 1'b0;
      end else if (remote_mode && !remote_q) begin
        // stop on transition / follow signal
        run_cmd_q <= bank_a_q[psm_pkg::SW_4] ? 1'b0 : ext_start;
      end else if (remote_mode) begin
        run_cmd_q <= ext_start && !remote_hold_q;
      end else begin
        run_cmd_q <= local_run_cmd;
      end
      if (remote_mode && bank_a_q[psm_pkg::SW_8]) begin
        booster_run_q <= run_cmd_q && ext_booster_start;
      end else begin
        booster_run_q <= run_cmd_q;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      primary_speed_q <= 8'h00;
      booster_speed_q <= 8'h00;
    end else begin
      primary_speed_q <= modes.primary_stage_ext_speed ?
        ext_primary_speed : local_primary_speed;
      booster_speed_q <= modes.booster_stage_ext_speed ?
        ext_booster_speed : local_booster_speed;
    end
  end
  // ---------------------------------------------------------------
  // monitoring window, buzzer, display timer
  // ---------------------------------------------------------------
  // monitoring window
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      monitor_cnt_q <= 40'h0;
      monitor_en_q <= 1'b1;
    end else begin
      if (pump_running) begin
        monitor_cnt_q <= 40'(MONITOR_CYCLES);
      end else if (monitor_cnt_q != 40'h0) begin
        monitor_cnt_q <= monitor_cnt_q - 40'h1;
      end
      monitor_en_q <= !bank_a_q[psm_pkg::SW_2] || pump_running ||
                      (monitor_cnt_q != 40'h0);
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      buzzer_q <= 1'b0;
    end else begin
      buzzer_q <= warn_alarm && modes.buzzer_en;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      display_cnt_q <= 32'(DISPLAY_CYCLES);
      display_home_q <= 1'b0;
    end else begin
      display_home_q <= 1'b0;
      if (display_activity || modes.display_locked) begin
        display_cnt_q <= 32'(DISPLAY_CYCLES);
      end else if (display_cnt_q > 32'h1) begin
        display_cnt_q <= display_cnt_q - 32'h1;
      end else begin
        display_home_q <= 1'b1;
        display_cnt_q <= 32'(DISPLAY_CYCLES);
      end
    end
  end
  always_comb begin
    purge_gas_warning_output = purge_gas_warning ^ bank_c_q[psm_pkg::SW_1];
    direct_signal_connector_one = conn_signals[0] && !modes.special_if_en;
    direct_signal_connector_two = conn_signals[1] && !modes.special_if_en;
  end
  // ---------------------------------------------------------------
  // interrupt status and register reads
  // ---------------------------------------------------------------
  logic [IRQ_W_L-1:0] irq_ev; // events this cycle
  always_comb begin
    irq_ev = '0;
    irq_ev[psm_pkg::IRQ_COMMIT] = ed_ok;
    irq_ev[psm_pkg::IRQ_REJECT] = ed_req && !ed_ok;
    irq_ev[psm_pkg::IRQ_RESTART_DONE] = restart_done;
    irq_ev[psm_pkg::IRQ_ABORT] = edit_active && warn_alarm;
  end
  // set wins over write-one clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
    end else begin
      if (bus_wr && bus_addr == psm_pkg::ADDR_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~bus_wdata[IRQ_W_L-1:0]) | irq_ev;
      end else begin
        irq_stat_q <= irq_stat_q | irq_ev;
      end
      if (bus_wr && bus_addr == psm_pkg::ADDR_IRQ_MASK) begin
        irq_mask_q <= bus_wdata[IRQ_W_L-1:0];
      end
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);
  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      case (bus_addr)
        psm_pkg::ADDR_BANK_A: bus_rdata <= bank_a_q;
        psm_pkg::ADDR_BANK_B: bus_rdata <= bank_b_q;
        psm_pkg::ADDR_BANK_C: bus_rdata <= bank_c_q;
        psm_pkg::ADDR_STATUS: bus_rdata <= {3'h0, restart_busy,
          edit_active, sel_q};
        psm_pkg::ADDR_IRQ_STAT: bus_rdata <= {4'h0, irq_stat_q};
        psm_pkg::ADDR_IRQ_MASK: bus_rdata <= {4'h0, irq_mask_q};
        default: bus_rdata <= 8'h00;
      endcase
    end else begin
      bus_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ### tb/psm_switch_mode_assertions.sv
// checker: port-level properties of the switch mode block
`timescale 1ns/1ps
`default_nettype none

module psm_switch_mode_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // watched inputs
  input wire psm_pkg::psm_keys_t keys,
  input wire logic warn_alarm,
  input wire logic [7:0] ext_primary_speed,
  input wire logic [7:0] local_primary_speed,
  input wire logic [7:0] ext_booster_speed,
  // watched outputs
  input wire psm_pkg::psm_modes_t modes,
  input wire logic run_cmd_q,
  input wire logic [7:0] primary_speed_q,
  input wire logic [7:0] booster_speed_q,
  input wire logic buzzer_q,
  input wire logic direct_signal_connector_one,
  input wire logic direct_signal_connector_two,
  input wire logic restart_busy,
  input wire logic display_home_q,
  input wire logic edit_active,
  input wire logic stop_pulse,
  input wire logic clear_pulse
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_frame_len: assert property (
    modes.data_len == 4'h7 || modes.data_len == 4'h8)
    else $error("frame length not seven or eight");
  a_buzzer_quiet: assert property (
    !modes.buzzer_en |=> !buzzer_q)
    else $error("buzzer sounded while disabled");
  a_restart_blocks_run: assert property (
    restart_busy |=> !run_cmd_q)
    else $error("run command during countdown");
  a_primary_speed_src: assert property (
    1'b1 |=> primary_speed_q == ($past(modes.primary_stage_ext_speed) ?
      $past(ext_primary_speed) : $past(local_primary_speed)))
    else $error("primary speed from wrong source");
  a_booster_speed_src: assert property (
    modes.booster_stage_ext_speed |=>
      booster_speed_q == $past(ext_booster_speed))
    else $error("booster speed not external");
  a_special_mute: assert property (
    modes.special_if_en |->
      !direct_signal_connector_one && !direct_signal_connector_two)
    else $error("connector driven with special interface");
  a_display_lock: assert property (
    modes.display_locked |=> !display_home_q)
    else $error("locked display returned home");
  a_enter_edit: assert property (
    keys.enter_screen && !warn_alarm |=> edit_active)
    else $error("session not opened");
  a_stop_key: assert property (
    keys.stop |-> stop_pulse)
    else $error("stop key lost");
  a_clear_key: assert property (
    keys.reset |-> clear_pulse)
    else $error("reset key lost");
  a_session_abort: assert property (
    edit_active && warn_alarm |=> !edit_active)
    else $error("session kept after warning");
endmodule

bind psm_switch_mode psm_switch_mode_assertions u_chk (
  .core_clk, .rst_n, .keys, .warn_alarm, .ext_primary_speed,
  .local_primary_speed, .ext_booster_speed, .modes, .run_cmd_q,
  .primary_speed_q, .booster_speed_q, .buzzer_q,
  .direct_signal_connector_one, .direct_signal_connector_two,
  .restart_busy, .display_home_q, .edit_active, .stop_pulse, .clear_pulse
);
`default_nettype wire

// ### tb/psm_partner.sv
// partner: display controller key pad and remote signal levels
`timescale 1ns/1ps
`default_nettype none

module psm_partner (
  // clock
  input wire logic core_clk,
  // key pad
  output psm_pkg::psm_keys_t keys,
  output logic [1:0] key_bank,
  output logic display_activity,
  // remote levels
  output logic remote_mode,
  output logic ext_start,
  output logic ext_booster_start
);
  // idle pad, local control
  initial begin
    keys = '0;
    key_bank = 2'h0;
    display_activity = 1'b0;
    remote_mode = 1'b0;
    ext_start = 1'b0;
    ext_booster_start = 1'b0;
  end

  task automatic press(input psm_pkg::psm_keys_t k, input logic [1:0] b);
    @(posedge core_clk);
    keys <= k;
    key_bank <= b;
    display_activity <= 1'b1;
    @(posedge core_clk);
    keys <= '0;
    display_activity <= 1'b0;
  endtask

  task automatic remote(input logic m, input logic s);
    @(posedge core_clk);
    remote_mode <= m;
    ext_start <= s;
    ext_booster_start <= s;
  endtask
endmodule
`default_nettype wire

// ### tb/psm_switch_mode_tb.sv
// testbench: self-checking scenarios for the switch mode block
`timescale 1ns/1ps
`default_nettype none

module psm_switch_mode_tb;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  localparam int unsigned RC = 20; // short countdown
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] bus_addr = 4'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic pump_running = 1'b0;
  logic warn_alarm = 1'b0;
  logic purge_gas_warning = 1'b1;
  logic [7:0] ext_primary_speed = 8'h00;
  logic [7:0] ext_booster_speed = 8'h5a;
  logic [7:0] local_primary_speed = 8'h11;
  logic [7:0] local_booster_speed = 8'h22;
  logic local_run_cmd = 1'b0;
  logic [1:0] conn_signals = 2'h0;
  psm_pkg::psm_keys_t keys;
  logic [1:0] key_bank;
  logic display_activity, remote_mode, ext_start, ext_booster_start;
  psm_pkg::psm_modes_t modes;
  logic [7:0] bus_rdata, primary_speed_q;
  logic irq, run_cmd_q, monitor_en_q, buzzer_q, purge_gas_warning_output;
  logic direct_signal_connector_one, restart_busy, edit_active;
  logic [2:0] edit_sel;
  int fail_count = 0;
  int comparisons = 0;

  always #20 core_clk = ~core_clk;

  psm_switch_mode #(.RESTART_CYCLES(RC), .DISPLAY_CYCLES(30),
    .MONITOR_CYCLES(40)) DUT (
    .core_clk, .rst_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .bus_rdata, .irq, .keys, .key_bank, .display_activity,
    .pump_running, .remote_mode, .ext_start, .ext_booster_start,
    .warn_alarm, .purge_gas_warning, .ext_primary_speed,
    .ext_booster_speed, .local_primary_speed, .local_booster_speed,
    .local_run_cmd, .conn_signals, .modes, .run_cmd_q,
    .booster_run_q(), .primary_speed_q, .booster_speed_q(),
    .monitor_en_q, .buzzer_q, .purge_gas_warning_output,
    .direct_signal_connector_one, .direct_signal_connector_two(),
    .restart_busy, .display_home_q(), .edit_active, .edit_sel,
    .stop_pulse(), .clear_pulse()
  );

  psm_partner u_part (
    .core_clk, .keys, .key_bank, .display_activity, .remote_mode,
    .ext_start, .ext_booster_start
  );

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] s,
                     input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one-cycle bus write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge core_clk);
    bus_wr <= 1'b0;
  endtask

  // read, data taken in the following cycle only
  task automatic rdc(input string n, input logic [3:0] a,
                     input logic [7:0] e);
    @(posedge core_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    @(negedge core_clk);
    chk(n, bus_rdata, e);
  endtask

  // bounded wait for the countdown to end
  task automatic wait_idle;
    for (int i = 0; i < 4 * RC; i++) begin
      @(negedge core_clk);
      if (restart_busy === 1'b0) break;
    end
    if (restart_busy !== 1'b0) begin
      fail_count++;
      report_and_stop();
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    @(negedge core_clk);
    chk("countdown", 8'(restart_busy), 8'h01);
    chk("monitor", 8'(monitor_en_q), 8'h01);
    rdc("bank a", psm_pkg::ADDR_BANK_A, psm_pkg::RESET_BANK_A);
    rdc("bank b", psm_pkg::ADDR_BANK_B, psm_pkg::RESET_BANK_B);
    rdc("bank c", psm_pkg::ADDR_BANK_C, psm_pkg::RESET_BANK_C);
    rdc("unmapped", 4'hf, 8'h00);
    chk("len", 8'(modes.data_len), 8'h08);
    chk("warn out", 8'(purge_gas_warning_output), 8'h01);
    wait_idle();
    rdc("done flag", psm_pkg::ADDR_IRQ_STAT, 8'h04);
    $display("reset test done");
  endtask

  task automatic t_edits;
    wr(psm_pkg::ADDR_BANK_A, 8'hc6);
    @(negedge core_clk);
    chk("len", 8'(modes.data_len), 8'h07);
    chk("dilution", 8'(modes.dilution_gas_off_mode), 8'h01);
    chk("booster ext", 8'(modes.booster_ext_start), 8'h01);
    chk("countdown", 8'(restart_busy), 8'h01);
    wait_idle();
    repeat (45) @(negedge core_clk);
    chk("monitor", 8'(monitor_en_q), 8'h00);
    wr(psm_pkg::ADDR_BANK_A, 8'hc2);
    @(negedge core_clk);
    chk("buzzer en", 8'(modes.buzzer_en), 8'h00);
    chk("buzzer exempt", 8'(restart_busy), 8'h00);
    wr(psm_pkg::ADDR_BANK_A, 8'hc6);
    ext_primary_speed <= 8'h3c;
    conn_signals <= 2'h3;
    wr(psm_pkg::ADDR_BANK_C, 8'h01);
    wr(psm_pkg::ADDR_BANK_B, 8'h83);
    repeat (2) @(negedge core_clk);
    chk("warn out", 8'(purge_gas_warning_output), 8'h00);
    chk("special if", 8'(modes.special_if_en), 8'h01);
    chk("conn one", 8'(direct_signal_connector_one), 8'h00);
    chk("ext primary", 8'(modes.primary_stage_ext_speed), 8'h01);
    chk("ext booster", 8'(modes.booster_stage_ext_speed), 8'h01);
    chk("lock", 8'(modes.display_locked), 8'h01);
    chk("speed", primary_speed_q, 8'h3c);
    wr(psm_pkg::ADDR_BANK_B, 8'h20);
    wr(psm_pkg::ADDR_BANK_C, 8'h00);
    repeat (2) @(negedge core_clk);
    chk("conn one", 8'(direct_signal_connector_one), 8'h01);
    chk("speed", primary_speed_q, 8'h11);
    $display("edit test done");
  endtask

  task automatic t_running;
    wait_idle();
    wr(psm_pkg::ADDR_IRQ_STAT, 8'hff);
    pump_running <= 1'b1;
    wr(psm_pkg::ADDR_BANK_A, 8'hc7);
    rdc("bank a held", psm_pkg::ADDR_BANK_A, 8'hc6);
    rdc("reject flag", psm_pkg::ADDR_IRQ_STAT, 8'h02);
    wr(psm_pkg::ADDR_BANK_A, 8'hca);
    rdc("bank a live", psm_pkg::ADDR_BANK_A, 8'hca);
    wr(psm_pkg::ADDR_IRQ_MASK, 8'h02);
    @(negedge core_clk);
    chk("irq", 8'(irq), 8'h01);
    wr(psm_pkg::ADDR_IRQ_STAT, 8'h02);
    @(negedge core_clk);
    chk("irq", 8'(irq), 8'h00);
    chk("monitor", 8'(monitor_en_q), 8'h01);
    wr(psm_pkg::ADDR_IRQ_MASK, 8'h00);
    pump_running <= 1'b0;
    repeat (4) @(negedge core_clk);
    chk("monitor hold", 8'(monitor_en_q), 8'h01);
    $display("running test done");
  endtask

  task automatic t_keys;
    u_part.press(7'h40, psm_pkg::BANK_A);
    @(negedge core_clk);
    chk("session", 8'(edit_active), 8'h01);
    u_part.press(7'h10, psm_pkg::BANK_A);
    u_part.press(7'h10, psm_pkg::BANK_A);
    @(negedge core_clk);
    chk("switch sel", 8'(edit_sel), 8'h02);
    u_part.press(7'h08, psm_pkg::BANK_A);
    rdc("set on", psm_pkg::ADDR_BANK_A, 8'hce);
    u_part.press(7'h04, psm_pkg::BANK_A);
    rdc("set off", psm_pkg::ADDR_BANK_A, 8'hca);
    u_part.press(7'h08, psm_pkg::BANK_A);
    u_part.press(7'h02, psm_pkg::BANK_A);
    @(posedge core_clk);
    warn_alarm <= 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
    chk("session", 8'(edit_active), 8'h00);
    chk("buzzer", 8'(buzzer_q), 8'h01);
    @(posedge core_clk);
    warn_alarm <= 1'b0;
    u_part.press(7'h01, psm_pkg::BANK_A);
    $display("key test done");
  endtask

  task automatic t_remote;
    wait_idle();
    u_part.remote(1'b1, 1'b1);
    repeat (3) @(negedge core_clk);
    chk("run", 8'(run_cmd_q), 8'h00);
    u_part.remote(1'b1, 1'b0);
    u_part.remote(1'b1, 1'b1);
    repeat (3) @(negedge core_clk);
    chk("run", 8'(run_cmd_q), 8'h01);
    u_part.remote(1'b0, 1'b0);
    wr(psm_pkg::ADDR_BANK_A, 8'hc6);
    wait_idle();
    u_part.remote(1'b1, 1'b1);
    repeat (3) @(negedge core_clk);
    chk("run", 8'(run_cmd_q), 8'h01);
    u_part.remote(1'b1, 1'b0);
    repeat (3) @(negedge core_clk);
    chk("run", 8'(run_cmd_q), 8'h00);
    $display("remote test done");
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_edits();
    t_running();
    t_keys();
    t_remote();
    report_and_stop();
  end
endmodule
`default_nettype wire
